// ==== core/rtcsa_pkg.sv ====
package rtcsa_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Clock and link timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned LINK_PERIOD_NS = 160;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // Phase step for a 65536 Hz tick, two ticks per 32768 Hz period
    localparam logic [31:0] NCO_STEP = 32'((64'd65536 << 32) / 64'(CLK_HZ));
    localparam int unsigned DIV_W = 16;
    localparam int unsigned TAP_32K = 0;
    localparam int unsigned TAP_1K = 5;
    localparam int unsigned TAP_1HZ = 15;
    ////////////////////////////////////////////////////////////////////////////
    // Device register map
    localparam logic [3:0] REG_EXT = 4'hd;
    localparam logic [3:0] REG_FLAG = 4'he;
    localparam logic [3:0] REG_CTRL = 4'hf;
    localparam int unsigned EXT_ZERO_BIT = 5;
    localparam int unsigned EXT_FREQ_SELECT_HI = 3;
    localparam int unsigned EXT_FREQ_SELECT_LO = 2;
    localparam int unsigned FLAG_TF_BIT = 4;
    localparam int unsigned FLAG_AF_BIT = 3;
    localparam int unsigned CTRL_TIE_BIT = 4;
    localparam int unsigned CTRL_AIE_BIT = 3;
    localparam int unsigned CTRL_HALT_BIT = 1;
    localparam logic [7:0] EXT_RST = 8'h0c;
    localparam logic [1:0] FREQ_SELECT_32K = 2'h0;
    localparam logic [1:0] FREQ_SELECT_1K = 2'h1;
    localparam logic [1:0] FREQ_SELECT_1HZ = 2'h2;
    localparam logic [1:0] FREQ_SELECT_GATED = 2'h3;
    localparam logic [3:0] MODE_WRITE = 4'h1;
    localparam logic [3:0] MODE_READ = 4'h9;
    ////////////////////////////////////////////////////////////////////////////
    // Host register map (APB byte addresses)
    localparam logic [7:0] OFS_OP = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RDATA = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [1:0] OP_OPEN = 2'h1;
    localparam logic [1:0] OP_BYTE = 2'h2;
    localparam logic [1:0] OP_CLOSE = 2'h3;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_PIN_BIT = 1;
    typedef enum logic [2:0] {
        RTCSA_D_IDLE = 3'b000,
        RTCSA_D_CMD = 3'b001,
        RTCSA_D_WRITE = 3'b010,
        RTCSA_D_READ = 3'b011,
        RTCSA_D_IGNORE = 3'b100
    } rtcsa_dstate_t;
    typedef enum logic [2:0] {
        RTCSA_H_IDLE = 3'b000,
        RTCSA_H_OPEN = 3'b001,
        RTCSA_H_LOW = 3'b010,
        RTCSA_H_HIGH = 3'b011,
        RTCSA_H_CLOSE = 3'b100
    } rtcsa_hstate_t;
endpackage : rtcsa_pkg

// ==== core/rtcsa_link_if.sv ====
`timescale 1ns/100ps
interface rtcsa_link_if;
    logic ce;
    logic sclk;
    logic h_dio_out;
    logic h_dio_oe;
    logic d_dio_out;
    logic d_dio_oe;
    logic irq_oe;
    logic serial_data_io;
    logic irq_n;
    // Wire levels with pull-ups on the shared pins
    assign serial_data_io = d_dio_oe ? d_dio_out : (h_dio_oe ? h_dio_out : 1'b1);
    assign irq_n = irq_oe ? 1'b0 : 1'b1;
    modport device (input ce, input sclk, input serial_data_io, output d_dio_out, output d_dio_oe, output irq_oe);
    modport host (output ce, output sclk, output h_dio_out, output h_dio_oe, input serial_data_io, input irq_n);
endinterface : rtcsa_link_if

// ==== core/rtcsa_device.sv ====
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module rtcsa_device
    import rtcsa_pkg::*;
(
    input wire logic clk_sys_in, // System clock
    input wire logic srst_in, // Power-on reset, sync high
    rtcsa_link_if.device link, // Serial link and interrupt pin
    input wire logic timer_event_in, // Fixed-cycle timer event pulse
    input wire logic alarm_event_in, // Alarm match event pulse
    input wire logic clock_out_enable_pin_in, // Clock output enable pin
    output logic clock_out_pin_out, // Clock output level
    output logic clock_out_pin_oe_out // Clock output drive enable
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    logic ce_s1_ff, ce_s2_ff;
    logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic din_s1_ff, din_s2_ff;
    logic foe_s1_ff, foe_s2_ff;

    always_ff @(posedge clk_sys_in)
    begin
        ce_s1_ff <= link.ce;
        ce_s2_ff <= ce_s1_ff;
        sclk_s1_ff <= link.sclk;
        sclk_s2_ff <= sclk_s1_ff;
        sclk_s3_ff <= sclk_s2_ff;
        din_s1_ff <= link.serial_data_io;
        din_s2_ff <= din_s1_ff;
        foe_s1_ff <= clock_out_enable_pin_in;
        foe_s2_ff <= foe_s1_ff;
    end

    // Link clock edges seen in the system domain
    wire sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
    wire sclk_fall = ~sclk_s2_ff & sclk_s3_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Serial framing state
    rtcsa_dstate_t st_ff, nxt_st;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic [3:0] addr_ff, nxt_addr;
    logic dout_ff, nxt_dout;
    logic doe_ff;
    logic [7:0] mem_ff [16];
    logic [7:0] nxt_mem [16];

    // Byte assembled from the shift register plus the current bit
    wire [7:0] in_byte = {sh_ff[6:0], din_s2_ff};
    wire last_bit = (bit_cnt_ff == 3'h7);
    wire cmd_done = (st_ff == RTCSA_D_CMD) && sclk_rise && last_bit;
    // A byte is stored only on its eighth bit while chip enable holds
    wire wr_byte = (st_ff == RTCSA_D_WRITE) && ce_s2_ff && sclk_rise && last_bit;
    wire rd_step = (st_ff == RTCSA_D_READ) && sclk_fall;
    wire [7:0] rd_byte = mem_ff[addr_ff];

    // Frame sequencer; chip enable low always returns to idle
    always_comb
    begin
        nxt_st = st_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_sh = sh_ff;
        nxt_addr = addr_ff;
        nxt_dout = dout_ff;
        if (!ce_s2_ff)
        begin
            nxt_st = RTCSA_D_IDLE;
            nxt_bit_cnt = 3'h0;
        end
        else
        begin
            case (st_ff)
                RTCSA_D_IDLE:
                begin
                    nxt_st = RTCSA_D_CMD;
                    nxt_bit_cnt = 3'h0;
                end
                RTCSA_D_CMD:
                begin
                    if (sclk_rise)
                    begin
                        nxt_sh = in_byte;
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                    end
                    if (cmd_done)
                    begin
                        // Mode in the upper nibble, address in the lower
                        nxt_addr = in_byte[3:0];
                        nxt_bit_cnt = 3'h0;
                        if (in_byte[7:4] == MODE_WRITE)
                            nxt_st = RTCSA_D_WRITE;
                        else if (in_byte[7:4] == MODE_READ)
                            nxt_st = RTCSA_D_READ;
                        else
                            nxt_st = RTCSA_D_IGNORE;
                    end
                end
                RTCSA_D_WRITE:
                begin
                    if (sclk_rise)
                    begin
                        nxt_sh = in_byte;
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                    end
                    if (wr_byte)
                        nxt_addr = addr_ff + 4'h1;
                end
                RTCSA_D_READ:
                begin
                    if (rd_step)
                    begin
                        // New byte on the first fall, then shift MSB first
                        if (bit_cnt_ff == 3'h0)
                        begin
                            nxt_dout = rd_byte[7];
                            nxt_sh = {rd_byte[6:0], 1'b0};
                        end
                        else
                        begin
                            nxt_dout = sh_ff[7];
                            nxt_sh = {sh_ff[6:0], 1'b0};
                        end
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                        if (last_bit)
                            nxt_addr = addr_ff + 4'h1;
                    end
                end
                RTCSA_D_IGNORE:
                    nxt_st = RTCSA_D_IGNORE;
                default:
                    nxt_st = RTCSA_D_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            st_ff <= RTCSA_D_IDLE;
            bit_cnt_ff <= 3'h0;
            sh_ff <= 8'h00;
            addr_ff <= 4'h0;
            dout_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            bit_cnt_ff <= nxt_bit_cnt;
            sh_ff <= nxt_sh;
            addr_ff <= nxt_addr;
            dout_ff <= nxt_dout;
        end
    end

    // Data pin driven only in a read frame; ignored modes stay high-Z
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            doe_ff <= 1'b0;
        else
            doe_ff <= (nxt_st == RTCSA_D_READ) && (doe_ff || rd_step);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file; events are merged after the write so set wins
    wire [7:0] evt_bits = (8'(timer_event_in) << FLAG_TF_BIT) | (8'(alarm_event_in) << FLAG_AF_BIT);

    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            nxt_mem[i] = mem_ff[i];
            if (wr_byte && (addr_ff == 4'(i)))
            begin
                // Flag bits only clear on a zero write, a one does nothing
                if (4'(i) == REG_FLAG)
                    nxt_mem[i] = mem_ff[i] & in_byte;
                else
                    nxt_mem[i] = in_byte;
                if (4'(i) == REG_EXT)
                    nxt_mem[i][EXT_ZERO_BIT] = 1'b0;
            end
            if (4'(i) == REG_FLAG)
                nxt_mem[i] = nxt_mem[i] | evt_bits;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (srst_in)
                mem_ff[i] <= (4'(i) == REG_EXT) ? EXT_RST : 8'h00;
            else
                mem_ff[i] <= nxt_mem[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin: pulled low while an enabled flag is set
    wire [7:0] flag_r = mem_ff[REG_FLAG];
    wire [7:0] ctrl_r = mem_ff[REG_CTRL];
    wire irq_tmr = flag_r[FLAG_TF_BIT] & ctrl_r[CTRL_TIE_BIT];
    wire irq_alm = flag_r[FLAG_AF_BIT] & ctrl_r[CTRL_AIE_BIT];
    logic irq_oe_ff;

    // Clearing the flag drops the enable, so the pin floats high again
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            irq_oe_ff <= 1'b0;
        else
            irq_oe_ff <= irq_tmr | irq_alm;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock output divider; NCO gives 65536 Hz ticks, jitter is one clock
    logic [31:0] nco_ff;
    logic [DIV_W-1:0] div_ff;
    logic clock_out_pin_ff, clock_out_pin_oe_ff;
    wire [32:0] nco_sum = {1'b0, nco_ff} + {1'b0, NCO_STEP};
    wire tick = nco_sum[32];
    wire [1:0] freq_select = {mem_ff[REG_EXT][EXT_FREQ_SELECT_HI], mem_ff[REG_EXT][EXT_FREQ_SELECT_LO]};
    wire halt = ctrl_r[CTRL_HALT_BIT];
    logic clock_out_pin_sel;

    // Frequency select; 1 Hz held low while counting is halted
    always_comb
    begin
        case (freq_select)
            FREQ_SELECT_32K: clock_out_pin_sel = div_ff[TAP_32K];
            FREQ_SELECT_1K: clock_out_pin_sel = div_ff[TAP_1K];
            FREQ_SELECT_1HZ: clock_out_pin_sel = halt ? 1'b0 : div_ff[TAP_1HZ];
            FREQ_SELECT_GATED: clock_out_pin_sel = div_ff[TAP_32K];
            default: clock_out_pin_sel = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            nco_ff <= 32'h0000_0000;
            div_ff <= '0;
            clock_out_pin_ff <= 1'b0;
            clock_out_pin_oe_ff <= 1'b0;
        end
        else
        begin
            nco_ff <= nco_sum[31:0];
            if (tick)
                div_ff <= div_ff + 1'b1;
            clock_out_pin_ff <= clock_out_pin_sel;
            clock_out_pin_oe_ff <= !((freq_select == FREQ_SELECT_GATED) && !foe_s2_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign link.d_dio_out = dout_ff;
    assign link.d_dio_oe = doe_ff;
    assign link.irq_oe = irq_oe_ff;
    assign clock_out_pin_out = clock_out_pin_ff;
    assign clock_out_pin_oe_out = clock_out_pin_oe_ff;
endmodule : rtcsa_device

// ==== core/rtcsa_host.sv ====
`timescale 1ns/100ps
module rtcsa_host
    import rtcsa_pkg::*;
#(
    parameter int unsigned HALF_CYC = LINK_HALF_CYC // Link clock half period in cycles
)
(
    input wire logic clk_sys_in, // System clock
    input wire logic srst_in, // Sync reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic irq_out, // Host interrupt level
    rtcsa_link_if.host link // Serial link to the device
);
    if (HALF_CYC < 4 || HALF_CYC > 65536)
    begin : g_half_chk
        $error("HALF_CYC out of range for the link logic");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for device-driven pins
    logic din_s1_ff, din_s2_ff, irq_s1_ff, irq_s2_ff, irq_s3_ff;
    always_ff @(posedge clk_sys_in)
    begin
        din_s1_ff <= link.serial_data_io;
        din_s2_ff <= din_s1_ff;
        irq_s1_ff <= link.irq_n;
        irq_s2_ff <= irq_s1_ff;
        irq_s3_ff <= irq_s2_ff;
    end
    wire irq_fell = ~irq_s2_ff & irq_s3_ff;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, unmapped addresses flag an error
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire hit = (paddr == OFS_OP) | (paddr == OFS_STATUS) | (paddr == OFS_RDATA) |
        (paddr == OFS_IRQ_STAT) | (paddr == OFS_IRQ_EN) | (paddr == OFS_IRQ_CLR);
    rtcsa_hstate_t st_ff, nxt_st;
    wire busy = (st_ff != RTCSA_H_IDLE);
    // Orders written while busy are dropped
    wire op_go = wr & (paddr == OFS_OP) & ~busy;
    wire [1:0] op = pwdata[1:0];

    logic [15:0] div_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] sh_ff, rdata_ff;
    logic ce_ff, sclk_ff, dout_ff, doe_ff, rd_mode_ff, cmd_ph_ff;
    logic [1:0] irq_stat_ff, irq_en_ff;
    wire half_done = (div_ff == 16'(HALF_CYC - 1));
    wire byte_end = (st_ff == RTCSA_H_HIGH) && half_done && (bit_cnt_ff == 3'h7);

    // Host sequencer; one order per byte, chip enable held between
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            RTCSA_H_IDLE:
                if (op_go && op == OP_OPEN)
                    nxt_st = RTCSA_H_OPEN;
                else if (op_go && op == OP_BYTE && ce_ff)
                    nxt_st = RTCSA_H_OPEN; // Lead-in loads the byte
                else if (op_go && op == OP_CLOSE)
                    nxt_st = RTCSA_H_CLOSE;
            RTCSA_H_OPEN: if (half_done) nxt_st = RTCSA_H_LOW;
            RTCSA_H_LOW: if (half_done) nxt_st = RTCSA_H_HIGH;
            RTCSA_H_HIGH: if (half_done) nxt_st = byte_end ? RTCSA_H_IDLE : RTCSA_H_LOW;
            RTCSA_H_CLOSE: if (half_done) nxt_st = RTCSA_H_IDLE;
            default: nxt_st = RTCSA_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            st_ff <= RTCSA_H_IDLE;
            div_ff <= 16'h0000;
            bit_cnt_ff <= 3'h0;
            sh_ff <= 8'h00;
            rdata_ff <= 8'h00;
            ce_ff <= 1'b0;
            sclk_ff <= 1'b0;
            dout_ff <= 1'b0;
            doe_ff <= 1'b0;
            rd_mode_ff <= 1'b0;
            cmd_ph_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            div_ff <= (st_ff == RTCSA_H_IDLE || half_done) ? 16'h0000 : div_ff + 16'h0001;
            if (op_go && op == OP_OPEN)
            begin
                // Command byte: mode nibble then address nibble
                ce_ff <= 1'b1;
                sh_ff <= pwdata[15:8];
                rd_mode_ff <= (pwdata[15:12] == MODE_READ);
                cmd_ph_ff <= 1'b1;
                bit_cnt_ff <= 3'h0;
            end
            if (op_go && op == OP_BYTE && ce_ff)
            begin
                sh_ff <= pwdata[15:8];
                cmd_ph_ff <= 1'b0;
                bit_cnt_ff <= 3'h0;
            end
            // Drive during command and write data; release for reads
            doe_ff <= (nxt_st == RTCSA_H_LOW || nxt_st == RTCSA_H_HIGH) && (cmd_ph_ff || !rd_mode_ff);
            if (nxt_st == RTCSA_H_LOW && st_ff != RTCSA_H_LOW)
            begin
                sclk_ff <= 1'b0;
                dout_ff <= sh_ff[7];
            end
            if (st_ff == RTCSA_H_LOW && half_done)
                sclk_ff <= 1'b1;
            // Sample late in the high phase, then fall and shift
            if (st_ff == RTCSA_H_HIGH && half_done)
            begin
                sclk_ff <= 1'b0;
                sh_ff <= {sh_ff[6:0], din_s2_ff};
                dout_ff <= sh_ff[6];
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'h7)
                    rdata_ff <= {sh_ff[6:0], din_s2_ff};
            end
            if (st_ff == RTCSA_H_CLOSE && half_done)
                ce_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status; a new event beats a clear in the same cycle
    wire [1:0] evt = {irq_fell, byte_end || (st_ff == RTCSA_H_CLOSE && half_done)};
    wire [1:0] clr = (wr && paddr == OFS_IRQ_CLR) ? pwdata[1:0] : 2'h0;
    logic irq_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            irq_stat_ff <= 2'h0;
            irq_en_ff <= 2'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= (irq_stat_ff & ~clr) | evt;
            if (wr && paddr == OFS_IRQ_EN)
                irq_en_ff <= pwdata[1:0];
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // Read mux
    wire [31:0] rd_mux = (paddr == OFS_STATUS) ? {29'h0, ~irq_s2_ff, ce_ff, busy} :
        (paddr == OFS_RDATA) ? {24'h0, rdata_ff} :
        (paddr == OFS_IRQ_STAT) ? {30'h0, irq_stat_ff} :
        (paddr == OFS_IRQ_EN) ? {30'h0, irq_en_ff} : 32'h0000_0000;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            prdata_ff <= (psel && !penable && !pwrite) ? rd_mux : prdata_ff;
            pslverr_ff <= psel && !penable && !hit;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff;
    assign irq_out = irq_ff;
    assign link.ce = ce_ff;
    assign link.sclk = sclk_ff;
    assign link.h_dio_out = dout_ff;
    assign link.h_dio_oe = doe_ff;
endmodule : rtcsa_host

// ==== tb/rtcsa_checker.sv ====
`timescale 1ns/100ps
module rtcsa_checker (
    input wire logic clk_sys_in, // Clock
    input wire logic srst_in, // Reset
    input wire logic ce, // Frame
    input wire logic sclk, // Link clock
    input wire logic h_dio_oe, // Host drive
    input wire logic h_dio_out, // Host data
    input wire logic d_dio_oe, // Device drive
    input wire logic irq_oe, // Irq pull
    input wire logic irq_n // Irq wire
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////////////////
    // Link clock framing; HALF_CYC is at least 4, so each phase lasts 4 cycles or more
    a_sclk_in_frame: assert property ($rose(sclk) |-> ce)
        else $error("sclk rose outside frame");
    a_sclk_idle_low: assert property (!ce |-> !sclk)
        else $error("sclk high without ce");
    a_frame_lead_low: assert property ($rose(ce) |-> (!sclk)[*4])
        else $error("sclk rose too soon after ce");
    a_high_phase_len: assert property ($rose(sclk) |-> sclk[*4])
        else $error("sclk high phase too short");
    // Data lines: host bit stable while sampled, no fight with the device
    a_host_bit_stable: assert property (sclk && $past(sclk) && h_dio_oe |-> $stable(h_dio_out))
        else $error("host data moved in high phase");
    a_no_contention: assert property (!(h_dio_oe && d_dio_oe))
        else $error("both ends drive dio");
    a_dev_drive_low: assert property ($rose(d_dio_oe) |-> !sclk)
        else $error("device began driving in high phase");
    // Device lets go of dio once the frame has ended; allows for its sync delay
    a_dev_quiet_idle: assert property ((!ce)[*6] |-> !d_dio_oe)
        else $error("device drives dio outside frame");
    a_irq_pulls_low: assert property (irq_oe |-> !irq_n)
        else $error("irq pull not seen on wire");
    c_dev_reads: cover property ($rose(d_dio_oe));
    c_irq_fell: cover property ($fell(irq_n));
    c_frame_end: cover property ($fell(ce));
endmodule : rtcsa_checker

// ==== tb/rtcsa_bench.sv ====
`timescale 1ns/100ps
module rtcsa_bench;
    import rtcsa_pkg::*;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic timer_event_in = 1'b0, alarm_event_in = 1'b0, clock_out_enable_pin_in = 1'b1;
    logic pready, pslverr, irq_out, clock_out_pin_out, clock_out_pin_oe_out, e, seen;
    int n_fail = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////////////////
    rtcsa_link_if link ();
    rtcsa_host rtcsa_host_i (.clk_sys_in, .srst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq_out, .link(link.host));
    rtcsa_device rtcsa_device_i (.clk_sys_in, .srst_in, .link(link.device), .timer_event_in, .alarm_event_in,
        .clock_out_enable_pin_in, .clock_out_pin_out, .clock_out_pin_oe_out);
    rtcsa_checker rtcsa_checker_i (.clk_sys_in, .srst_in, .ce(link.ce), .sclk(link.sclk),
        .h_dio_oe(link.h_dio_oe), .h_dio_out(link.h_dio_out), .d_dio_oe(link.d_dio_oe),
        .irq_oe(link.irq_oe), .irq_n(link.irq_n));
    // System clock
    initial
    begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Sticky note of any device drive on dio
    always @(posedge clk_sys_in)
        if (link.d_dio_oe === 1'b1) seen <= 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    // One APB transfer, entered just after a rising edge; ends one idle edge later
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask : apb
    // Link operation; polls the done bit, close waits out the ce hold
    task automatic op(input logic [1:0] o, input logic [7:0] b);
        apb(1'b1, OFS_IRQ_CLR, 32'h1);
        apb(1'b1, OFS_OP, {16'h0, b, 6'h0, o});
        if (o == OP_CLOSE) repeat (3 * LINK_HALF_CYC) @(posedge clk_sys_in);
        else do apb(1'b0, OFS_IRQ_STAT, 32'h0); while (r[IRQ_DONE_BIT] !== 1'b1);
    endtask : op
    // Single-byte device access; r[7:0] holds the read byte afterwards
    task automatic dev(input logic rd, input logic [3:0] a, input logic [7:0] w);
        op(OP_OPEN, {rd ? MODE_READ : MODE_WRITE, a});
        op(OP_BYTE, w);
        op(OP_CLOSE, 8'h00);
        apb(1'b0, OFS_RDATA, 32'h0);
    endtask : dev
    task automatic pulse(input logic t);
        if (t) timer_event_in <= 1'b1;
        else alarm_event_in <= 1'b1;
        @(posedge clk_sys_in);
        timer_event_in <= 1'b0;
        alarm_event_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        dev(1'b1, REG_EXT, 8'h00);
        chk("ext reset", 32'h0c, r[7:0]);
        chk("clock_out_pin oe reset", 1, clock_out_pin_oe_out);
        clock_out_enable_pin_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        chk("clock_out_pin off", 0, clock_out_pin_oe_out);
        $display("test reset done");
    endtask : t_reset
    // Halt set and pin low: 32768 and 1024 still run, 1 Hz held; window is four 32768 periods
    task automatic t_freq();
        int n;
        logic p;
        dev(1'b0, REG_CTRL, 8'h02);
        for (int s = 0; s < 3; s++)
        begin
            dev(1'b0, REG_EXT, 8'h20 | 8'(s << 2));
            dev(1'b1, REG_EXT, 8'h00);
            chk("ext sel", 8'(s << 2), r[7:0]);
            chk("clock_out_pin on", 1, clock_out_pin_oe_out);
            n = 0;
            p = clock_out_pin_out;
            repeat (12207)
            begin
                @(posedge clk_sys_in);
                n += int'(clock_out_pin_out && !p);
                p = clock_out_pin_out;
            end
            chk("clock_out_pin rate", 1, s == 0 ? (n >= 3 && n <= 5) : s == 1 ? n <= 1 : n == 0);
        end
        chk("1hz held", 0, clock_out_pin_out);
        dev(1'b0, REG_CTRL, 8'h00);
        $display("test freq done");
    endtask : t_freq
    task automatic t_irq();
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 1, e);
        apb(1'b1, OFS_IRQ_EN, 32'h2);
        dev(1'b0, REG_CTRL, 8'h18);
        pulse(1'b0);
        chk("irq alarm", 0, link.irq_n);
        chk("host irq", 1, irq_out);
        dev(1'b0, REG_FLAG, 8'h08);
        chk("irq kept", 0, link.irq_n);
        dev(1'b1, REG_FLAG, 8'h00);
        chk("flags alarm", 8'h08, r[7:0]);
        dev(1'b0, REG_FLAG, 8'h00);
        chk("irq released", 1, link.irq_n);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        apb(1'b1, OFS_IRQ_CLR, 32'h2);
        chk("host irq masked", 0, irq_out);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("pin event clr", 0, r[IRQ_PIN_BIT]);
        pulse(1'b1);
        chk("irq timer", 0, link.irq_n);
        dev(1'b0, REG_CTRL, 8'h00);
        chk("irq off", 1, link.irq_n);
        pulse(1'b0);
        chk("irq quiet", 1, link.irq_n);
        dev(1'b1, REG_FLAG, 8'h00);
        chk("flags polled", 8'h18, r[7:0]);
        dev(1'b0, REG_FLAG, 8'h00);
        $display("test irq done");
    endtask : t_irq
    // Write from F round through 0..C to D, read D..F, then a bad mode code
    task automatic t_burst();
        logic [7:0] x [3] = '{8'h04, 8'h00, 8'h10};
        op(OP_OPEN, {MODE_WRITE, REG_CTRL});
        op(OP_BYTE, 8'h10);
        for (int i = 0; i < 13; i++) op(OP_BYTE, 8'h00);
        op(OP_BYTE, 8'h04);
        op(OP_CLOSE, 8'h00);
        op(OP_OPEN, {MODE_READ, REG_EXT});
        for (int i = 0; i < 3; i++)
        begin
            op(OP_BYTE, 8'h00);
            apb(1'b0, OFS_RDATA, 32'h0);
            chk("burst read", x[i], r[7:0]);
        end
        op(OP_CLOSE, 8'h00);
        seen = 1'b0;
        op(OP_OPEN, 8'h5d);
        op(OP_BYTE, 8'hff);
        op(OP_CLOSE, 8'h00);
        chk("dio quiet", 0, seen);
        dev(1'b1, REG_EXT, 8'h00);
        chk("ext kept", 8'h04, r[7:0]);
        $display("test burst done");
    endtask : t_burst
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        @(posedge clk_sys_in);
        t_reset();
        t_freq();
        t_irq();
        t_burst();
        give_verdict();
    end
    // Watchdog, well beyond the expected run
    initial
    begin
        repeat (90000) @(posedge clk_sys_in);
        n_fail++;
        give_verdict();
    end
endmodule : rtcsa_bench
